/* File: design/pwm_channel_output_stage.sv */
// four-channel output stage: gray counter, dead time, override, fault forcing
`timescale 1ns/1ns
// What this block does
// R1 - channel pair can output two-bit gray count
// R2 - gray enable drives channels 0 and 1
// R3 - gray direction changes while counter runs
// R4 - dead time gives complementary non-overlapping outputs
// R5 - software changes dead-time enable only when disabled
// R6 - dead-time counter delays each edge by value
// R7 - dead-time updates apply at period boundary
// R8 - each dead-time output has invert bit
// R9 - override selection replaces outputs with values
// R10 - set and clear touch written channels only
// R11 - direct writes immediate, buffered at period start
// R12 - selection readback shows active selection
// R13 - eight faults force outputs, above override
// R14 - software sets fault polarity, internal active high
// R15 - filter rejects pulses under one clock
// R16 - fault level mode or latched until cleared
// R17 - status shows input levels and active faults
// R18 - per-channel fault enables, sync group uses ch0
// R19 - trigger needs enabled channel; unfiltered acts clockless
// R20 - trigger resets counter, forces 0, 1 or hi-z
// R21 - software sets polarity before mode or enable
// R22 - fault interrupt set on trigger, read clears
// R23 - gray order 00 01 11 10, once per period
module pwm_channel_output_stage
   import pwm_out_pkg::*;
#(
   parameter int DTW = DT_W
)
(
   input  wire logic                            sys_clk,
   input  wire logic                            nrst,
   input  wire logic [NUM_CH-1:0]               chan_tick,
   input  wire logic [NUM_CH-1:0]               period_end,
   input  wire logic [NUM_CH-1:0]               compare_out,
   input  wire logic [NUM_CH-1:0]               chan_enabled,
   input  wire logic [NUM_CH-1:0]               sync_group,
   input  wire logic                            gray_enable_pair0,
   input  wire logic                            gray_count_down,
   input  wire logic [NUM_CH-1:0]               deadtime_enable,
   input  wire logic [NUM_CH-1:0]               deadtime_high_invert,
   input  wire logic [NUM_CH-1:0]               deadtime_low_invert,
   input  wire logic [NUM_CH-1:0]               deadtime_update_wr,
   input  wire logic [NUM_CH-1:0][DTW-1:0]      deadtime_high_value,
   input  wire logic [NUM_CH-1:0][DTW-1:0]      deadtime_low_value,
   input  wire logic [NUM_CH-1:0]               override_value_high,
   input  wire logic [NUM_CH-1:0]               override_value_low,
   input  wire logic                            override_set_wr,
   input  wire logic                            override_clear_wr,
   input  wire logic                            override_set_buffered_wr,
   input  wire logic                            override_clear_buffered_wr,
   input  wire logic [NUM_CH-1:0]               override_wdata_high,
   input  wire logic [NUM_CH-1:0]               override_wdata_low,
   input  wire logic [NUM_FAULT-1:0]            fault_pin,
   input  wire logic [NUM_FAULT-1:0]            fault_polarity,
   input  wire logic [NUM_FAULT-1:0]            fault_activation_mode,
   input  wire logic [NUM_FAULT-1:0]            fault_filter_enable,
   input  wire logic                            fault_clear_wr,
   input  wire logic [NUM_FAULT-1:0]            fault_clear_bit,
   input  wire logic [NUM_CH-1:0][NUM_FAULT-1:0] fault_channel_enable,
   input  wire logic [NUM_CH-1:0]               fault_value_high,
   input  wire logic [NUM_CH-1:0]               fault_value_low,
   input  wire logic [NUM_CH-1:0]               fault_tristate_high,
   input  wire logic [NUM_CH-1:0]               fault_tristate_low,
   input  wire logic [NUM_CH-1:0]               fault_irq_enable,
   input  wire logic                            fault_irq_status_rd,
   output logic [NUM_CH-1:0]                    override_sel_high,
   output logic [NUM_CH-1:0]                    override_sel_low,
   output logic [NUM_FAULT-1:0]                 fault_input_level,
   output logic [NUM_FAULT-1:0]                 fault_active_flags,
   output logic [NUM_CH-1:0]                    fault_irq_status,
   output logic                                 fault_irq,
   output logic [NUM_CH-1:0]                    counter_reset,
   output logic [NUM_CH-1:0]                    output_high_pin,
   output logic [NUM_CH-1:0]                    output_high_oe,
   output logic [NUM_CH-1:0]                    output_low_pin,
   output logic [NUM_CH-1:0]                    output_low_oe
);
   gray_state_t          gray_q;
   logic [NUM_CH-1:0]    wave_in, dt_high, dt_low, trip, trip_prev_q;
   logic [NUM_CH-1:0]    osh_q, osl_q, psh_q, psl_q, pch_q, pcl_q;
   logic [NUM_CH-1:0]    ov_high, ov_low;
   logic [NUM_FAULT-1:0] fault_trip;
   logic [NUM_CH-1:0]    apply_set_h, apply_set_l, apply_clr_h, apply_clr_l;

   // gray counter steps once per channel 0 period
   always_ff @(posedge sys_clk) begin
      if (!nrst)
         gray_q <= GRAY_00;
      else if (gray_enable_pair0 && period_end[0])
         gray_q <= gray_next(gray_q, gray_count_down); // R3 R23
   end

   // gray bits replace the comparator of channels 0 and 1, dead time still follows
   always_comb begin
      wave_in = compare_out;
      if (gray_enable_pair0) begin
         wave_in[0] = gray_q[0]; // R1 R2
         wave_in[1] = gray_q[1]; // R1 R2
      end
   end

   for (genvar c = 0; c < NUM_CH; c++) begin : g_dt
      pwm_deadtime_gen #(.W(DTW)) u_dt (
         .sys_clk              (sys_clk),
         .nrst                 (nrst),
         .chan_tick            (chan_tick[c]),
         .period_end           (period_end[c]),
         .compare_out          (wave_in[c]),
         .deadtime_enable      (deadtime_enable[c]),
         .deadtime_high_invert (deadtime_high_invert[c]),
         .deadtime_low_invert  (deadtime_low_invert[c]),
         .deadtime_update_wr   (deadtime_update_wr[c]),
         .deadtime_high_value  (deadtime_high_value[c]),
         .deadtime_low_value   (deadtime_low_value[c]),
         .deadtime_out_high    (dt_high[c]),
         .deadtime_out_low     (dt_low[c])
      );
   end

   for (genvar f = 0; f < NUM_FAULT; f++) begin : g_fault
      pwm_fault_input u_fault (
         .sys_clk               (sys_clk),
         .nrst                  (nrst),
         .fault_pin             (fault_pin[f]),
         .fault_polarity        (fault_polarity[f]),
         .fault_activation_mode (fault_activation_mode[f]),
         .fault_filter_enable   (fault_filter_enable[f]),
         .fault_clear_wr        (fault_clear_wr),
         .fault_clear_bit       (fault_clear_bit[f]),
         .fault_input_level     (fault_input_level[f]),
         .fault_active_flag     (fault_active_flags[f]),
         .fault_trip            (fault_trip[f])
      );
   end

   // buffered set and clear masks wait for each channel's period start
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         psh_q <= OVR_SEL_RST;
         psl_q <= OVR_SEL_RST;
         pch_q <= OVR_SEL_RST;
         pcl_q <= OVR_SEL_RST;
      end else begin
         psh_q <= (psh_q & ~period_end) | ({NUM_CH{override_set_buffered_wr}} & override_wdata_high);
         psl_q <= (psl_q & ~period_end) | ({NUM_CH{override_set_buffered_wr}} & override_wdata_low);
         pch_q <= (pch_q & ~period_end) | ({NUM_CH{override_clear_buffered_wr}} & override_wdata_high);
         pcl_q <= (pcl_q & ~period_end) | ({NUM_CH{override_clear_buffered_wr}} & override_wdata_low);
      end
   end

   assign apply_set_h = ({NUM_CH{override_set_wr}} & override_wdata_high) | (psh_q & period_end); // R11
   assign apply_set_l = ({NUM_CH{override_set_wr}} & override_wdata_low) | (psl_q & period_end); // R11
   assign apply_clr_h = ({NUM_CH{override_clear_wr}} & override_wdata_high) | (pch_q & period_end); // R11
   assign apply_clr_l = ({NUM_CH{override_clear_wr}} & override_wdata_low) | (pcl_q & period_end); // R11

   // only written channels change, set wins over clear
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         osh_q <= OVR_SEL_RST;
         osl_q <= OVR_SEL_RST;
      end else begin
         osh_q <= set_clr(osh_q, apply_set_h, apply_clr_h); // R10
         osl_q <= set_clr(osl_q, apply_set_l, apply_clr_l); // R10
      end
   end

   assign override_sel_high = osh_q; // R12
   assign override_sel_low  = osl_q; // R12
   assign ov_high = (osh_q & override_value_high) | (~osh_q & dt_high); // R9
   assign ov_low  = (osl_q & override_value_low) | (~osl_q & dt_low); // R9

   // fault trigger per channel; sync group members use channel 0 enables
   always_comb begin
      for (int c = 0; c < NUM_CH; c++) begin
         if (sync_group[c])
            trip[c] = chan_enabled[c] && |(fault_trip & fault_channel_enable[0]); // R18 R19
         else
            trip[c] = chan_enabled[c] && |(fault_trip & fault_channel_enable[c]); // R18 R19
      end
   end

   assign counter_reset = trip; // R20

   // fault forcing sits above override and does not wait for a clock
   always_comb begin
      for (int c = 0; c < NUM_CH; c++) begin
         if (trip[c]) begin
            output_high_pin[c] = fault_value_high[c] & ~fault_tristate_high[c]; // R13 R20
            output_high_oe[c]  = ~fault_tristate_high[c]; // R20
            output_low_pin[c]  = fault_value_low[c] & ~fault_tristate_low[c]; // R13 R20
            output_low_oe[c]   = ~fault_tristate_low[c]; // R20
         end else begin
            output_high_pin[c] = ov_high[c];
            output_high_oe[c]  = 1'b1;
            output_low_pin[c]  = ov_low[c];
            output_low_oe[c]   = 1'b1;
         end
      end
   end

   // interrupt flags: set on trigger onset, cleared by status read, set wins
   always_ff @(posedge sys_clk) begin
      if (!nrst)
         trip_prev_q <= '0;
      else
         trip_prev_q <= trip;
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst)
         fault_irq_status <= IRQ_STAT_RST;
      else
         fault_irq_status <= set_clr(fault_irq_status, trip & ~trip_prev_q,
                                     {NUM_CH{fault_irq_status_rd}}); // R22
   end

   assign fault_irq = |(fault_irq_status & fault_irq_enable); // R22

   sequence s_period_gray;
      gray_enable_pair0 && period_end[0];
   endsequence

   property p_gray_step;
      @(posedge sys_clk) disable iff (!nrst)
         s_period_gray |=> gray_q == gray_next($past(gray_q), $past(gray_count_down));
   endproperty
   a_gray_step: assert property (p_gray_step) // R23
      else $error("gray counter took a wrong step");

   property p_gray_hold;
      @(posedge sys_clk) disable iff (!nrst)
         !period_end[0] |=> $stable(gray_q);
   endproperty
   a_gray_hold: assert property (p_gray_hold) // R23
      else $error("gray counter moved off a period boundary");

   property p_gray_drive;
      @(posedge sys_clk) disable iff (!nrst)
         gray_enable_pair0 |-> wave_in[1:0] == gray_q;
   endproperty
   a_gray_drive: assert property (p_gray_drive) // R2
      else $error("channels 0 and 1 not driven by gray count");

   property p_ovr_direct;
      @(posedge sys_clk) disable iff (!nrst)
         (override_set_wr && !override_clear_wr && !override_clear_buffered_wr)
            |=> (osh_q & $past(override_wdata_high)) == $past(override_wdata_high);
   endproperty
   a_ovr_direct: assert property (p_ovr_direct) // R11
      else $error("direct override set not applied next cycle");

   sequence s_buf_set;
      override_set_buffered_wr && override_wdata_high[1] && !period_end[1];
   endsequence

   property p_ovr_buffered;
      @(posedge sys_clk) disable iff (!nrst)
         (s_buf_set ##[1:3] (period_end[1] && !override_clear_wr)) |=> osh_q[1];
   endproperty
   a_ovr_buffered: assert property (p_ovr_buffered) // R11
      else $error("buffered override not applied at period start");

   property p_ovr_others;
      @(posedge sys_clk) disable iff (!nrst)
         (override_set_wr && !override_wdata_high[1] && !override_clear_wr && !period_end[1])
            |=> osh_q[1] == $past(osh_q[1]);
   endproperty
   a_ovr_others: assert property (p_ovr_others) // R10
      else $error("override set touched an unwritten channel");

   property p_fault_force;
      @(posedge sys_clk) disable iff (!nrst)
         trip[2] |-> output_high_oe[2] == !fault_tristate_high[2]
                     && (fault_tristate_high[2] || output_high_pin[2] == fault_value_high[2]);
   endproperty
   a_fault_force: assert property (p_fault_force) // R13
      else $error("fault forcing value wrong");

   property p_trip_enable;
      @(posedge sys_clk) disable iff (!nrst)
         !chan_enabled[3] |-> !trip[3] && !counter_reset[3];
   endproperty
   a_trip_enable: assert property (p_trip_enable) // R19
      else $error("fault acted on a disabled channel");

   property p_irq_set;
      @(posedge sys_clk) disable iff (!nrst)
         (trip[1] && !trip_prev_q[1]) |=> fault_irq_status[1];
   endproperty
   a_irq_set: assert property (p_irq_set) // R22
      else $error("fault trigger did not set interrupt flag");

   property p_irq_clear;
      @(posedge sys_clk) disable iff (!nrst)
         (fault_irq_status_rd && !(trip[1] && !trip_prev_q[1])) |=> !fault_irq_status[1];
   endproperty
   a_irq_clear: assert property (p_irq_clear) // R22
      else $error("status read did not clear interrupt flag");
endmodule

/* File: design/pwm_deadtime_gen.sv */
// dead-time generator for one channel
`timescale 1ns/1ns
module pwm_deadtime_gen
   import pwm_out_pkg::*;
#(
   parameter int W = DT_W
)
(
   input  wire logic         sys_clk,
   input  wire logic         nrst,
   input  wire logic         chan_tick,
   input  wire logic         period_end,
   input  wire logic         compare_out,
   input  wire logic         deadtime_enable,
   input  wire logic         deadtime_high_invert,
   input  wire logic         deadtime_low_invert,
   input  wire logic         deadtime_update_wr,
   input  wire logic [W-1:0] deadtime_high_value,
   input  wire logic [W-1:0] deadtime_low_value,
   output logic              deadtime_out_high,
   output logic              deadtime_out_low
);
   logic [W-1:0] dth_q, dtl_q, pend_h_q, pend_l_q, cnt_q;
   logic         pend_q, oc_q, high_q, low_q, edge_seen;

   assign edge_seen = (compare_out != oc_q);

   always_ff @(posedge sys_clk) begin
      if (!nrst)
         oc_q <= 1'b0;
      else
         oc_q <= compare_out;
   end

   // new values wait for the period boundary
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         pend_h_q <= DT_VAL_RST;
         pend_l_q <= DT_VAL_RST;
         pend_q   <= 1'b0;
         dth_q    <= DT_VAL_RST;
         dtl_q    <= DT_VAL_RST;
      end else begin
         if (deadtime_update_wr) begin
            pend_h_q <= deadtime_high_value;
            pend_l_q <= deadtime_low_value;
         end
         pend_q <= deadtime_update_wr | (pend_q & ~period_end);
         if (period_end && pend_q) begin
            dth_q <= pend_h_q; // R7
            dtl_q <= pend_l_q; // R7
         end
      end
   end

   // counter on the channel clock, restarted at each edge, saturating
   always_ff @(posedge sys_clk) begin
      if (!nrst)
         cnt_q <= '0;
      else if (edge_seen)
         cnt_q <= '0; // R6
      else if (chan_tick && cnt_q != '1)
         cnt_q <= cnt_q + 1'b1; // R6
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         high_q <= 1'b0;
         low_q  <= 1'b0;
      end else if (!deadtime_enable) begin
         high_q <= compare_out;
         low_q  <= ~compare_out;
      end else if (edge_seen) begin
         high_q <= compare_out && dth_q == '0; // R4
         low_q  <= !compare_out && dtl_q == '0; // R4
      end else begin
         high_q <= compare_out && cnt_q >= dth_q; // R6
         low_q  <= !compare_out && cnt_q >= dtl_q; // R6
      end
   end

   assign deadtime_out_high = high_q ^ deadtime_high_invert; // R8
   assign deadtime_out_low  = low_q ^ deadtime_low_invert; // R8

   property p_no_overlap;
      @(posedge sys_clk) disable iff (!nrst)
         deadtime_enable |-> !(high_q && low_q);
   endproperty
   a_no_overlap: assert property (p_no_overlap) // R4
      else $error("high and low sides overlap");

   property p_high_waits;
      @(posedge sys_clk) disable iff (!nrst)
         (deadtime_enable && compare_out && !edge_seen && cnt_q < dth_q) |=> !high_q;
   endproperty
   a_high_waits: assert property (p_high_waits) // R6
      else $error("high side rose before dead time");
endmodule

/* File: design/pwm_fault_input.sv */
// one fault input: synchroniser, glitch filter, polarity and latch
`timescale 1ns/1ns
module pwm_fault_input
   import pwm_out_pkg::*;
(
   input  wire logic sys_clk,
   input  wire logic nrst,
   input  wire logic fault_pin,
   input  wire logic fault_polarity,
   input  wire logic fault_activation_mode,
   input  wire logic fault_filter_enable,
   input  wire logic fault_clear_wr,
   input  wire logic fault_clear_bit,
   output logic      fault_input_level,
   output logic      fault_active_flag,
   output logic      fault_trip
);
   logic sync1_q, sync2_q, samp_q, filt_q, act_prev_q, latch_q;
   logic lvl, act_lvl, raw_act;

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
      end else begin
         sync1_q <= fault_pin;
         sync2_q <= sync1_q;
      end
   end

   // filter: level only passes after it held for FILTER_CYCLES + 1 samples
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         samp_q <= 1'b0;
         filt_q <= 1'b0;
      end else begin
         samp_q <= sync2_q;
         if (samp_q == sync2_q)
            filt_q <= sync2_q; // R15
      end
   end

   assign lvl     = fault_filter_enable ? filt_q : sync2_q;
   assign act_lvl = (lvl == fault_polarity);
   // unfiltered path acts straight from the pin, needs no clock
   assign raw_act = (fault_pin == fault_polarity); // R19

   always_ff @(posedge sys_clk) begin
      if (!nrst)
         act_prev_q <= 1'b1;
      else
         act_prev_q <= act_lvl;
   end

   // latched mode: set on transition, clear only once input inactive
   always_ff @(posedge sys_clk) begin
      if (!nrst)
         latch_q <= 1'b0;
      else if (fault_activation_mode && act_lvl && !act_prev_q)
         latch_q <= 1'b1; // R16
      else if (fault_clear_wr && fault_clear_bit && !act_lvl)
         latch_q <= 1'b0; // R16
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         fault_input_level <= 1'b0;
         fault_active_flag <= 1'b0;
      end else begin
         fault_input_level <= lvl; // R17
         fault_active_flag <= fault_activation_mode ? latch_q : act_lvl; // R17
      end
   end

   always_comb begin
      if (fault_activation_mode)
         fault_trip = latch_q | (fault_filter_enable ? act_lvl : raw_act);
      else
         fault_trip = fault_filter_enable ? act_lvl : raw_act;
   end

   property p_latch_hold;
      @(posedge sys_clk) disable iff (!nrst)
         (fault_activation_mode && latch_q && !fault_clear_wr) |=> latch_q;
   endproperty
   a_latch_hold: assert property (p_latch_hold) // R16
      else $error("latched fault dropped without clear");

   property p_filter_rejects;
      @(posedge sys_clk) disable iff (!nrst)
         (samp_q != sync2_q) |=> $stable(filt_q);
   endproperty
   a_filter_rejects: assert property (p_filter_rejects) // R15
      else $error("filter passed a one-sample glitch");
endmodule

/* File: design/pwm_out_pkg.sv */
// shared constants and types for the channel output stage
package pwm_out_pkg;
   localparam int NUM_CH    = 4;
   localparam int NUM_FAULT = 8;
   localparam int DT_W      = 16;

   // reset values
   localparam logic [3:0] OVR_SEL_RST  = 4'h0;
   localparam logic [3:0] IRQ_STAT_RST = 4'h0;
   localparam logic [DT_W-1:0] DT_VAL_RST = 16'h0000;

   // glitch filter: input must hold this many peripheral clocks plus one (two samples) to pass
   localparam int FILTER_CYCLES = 1;

   // gray counter states, sequence 00 01 11 10
   typedef enum logic [1:0] {
      GRAY_00 = 2'b00,
      GRAY_01 = 2'b01,
      GRAY_11 = 2'b11,
      GRAY_10 = 2'b10
   } gray_state_t;

   function automatic gray_state_t gray_next(input gray_state_t cur, input logic down);
      gray_state_t nxt;
      nxt = cur;
      unique case (cur)
         GRAY_00: nxt = down ? GRAY_10 : GRAY_01;
         GRAY_01: nxt = down ? GRAY_00 : GRAY_11;
         GRAY_11: nxt = down ? GRAY_01 : GRAY_10;
         GRAY_10: nxt = down ? GRAY_11 : GRAY_00;
      endcase
      return nxt;
   endfunction

   // set wins over clear for sticky or selection bits
   function automatic logic [3:0] set_clr(input logic [3:0] cur, input logic [3:0] set,
                                          input logic [3:0] clr);
      return (cur & ~clr) | set;
   endfunction
endpackage

/* File: verification/ext_switch_stage.sv */
// partner model: external power switch gates driven by the output pins
`timescale 1ns/1ns
module ext_switch_stage
   import pwm_out_pkg::*;
(
   input  wire logic [NUM_CH-1:0] hi_pin,
   input  wire logic [NUM_CH-1:0] hi_oe,
   input  wire logic [NUM_CH-1:0] lo_pin,
   input  wire logic [NUM_CH-1:0] lo_oe,
   output logic      [NUM_CH-1:0] gate_high,
   output logic      [NUM_CH-1:0] gate_low,
   output logic                   shoot_through
);
   // gate inputs have pull-downs, hi-z reads 0
   assign gate_high = hi_pin & hi_oe;
   assign gate_low = lo_pin & lo_oe;
   // both switches of a leg on at once
   assign shoot_through = |(gate_high & gate_low);
endmodule

/* File: verification/tb_top.sv */
// self-checking bench for the channel output stage
`timescale 1ns/1ns
module tb_top
   import pwm_out_pkg::*;
;
   logic sys_clk, nrst, gray_enable_pair0, gray_count_down, override_set_wr, override_clear_wr, fault_irq;
   logic override_set_buffered_wr, override_clear_buffered_wr, fault_clear_wr, fault_irq_status_rd;
   logic [NUM_CH-1:0] chan_tick, period_end, compare_out, chan_enabled, sync_group, deadtime_enable;
   logic [NUM_CH-1:0] deadtime_high_invert, deadtime_low_invert, deadtime_update_wr, override_value_high;
   logic [NUM_CH-1:0] override_value_low, override_wdata_high, override_wdata_low, fault_value_high;
   logic [NUM_CH-1:0] fault_value_low, fault_tristate_high, fault_tristate_low, fault_irq_enable;
   logic [NUM_CH-1:0] override_sel_high, override_sel_low, fault_irq_status, counter_reset, gate_high;
   logic [NUM_CH-1:0] output_high_pin, output_high_oe, output_low_pin, output_low_oe, gate_low;
   logic [NUM_FAULT-1:0] fault_pin, fault_polarity, fault_activation_mode, fault_filter_enable;
   logic [NUM_FAULT-1:0] fault_clear_bit, fault_input_level, fault_active_flags;
   logic [NUM_CH-1:0][DT_W-1:0] deadtime_high_value, deadtime_low_value;
   logic [NUM_CH-1:0][NUM_FAULT-1:0] fault_channel_enable;
   logic shoot_through;
   int failures = 0;
   int total_checks = 0;
   // op set/clear/both, wdata high, wdata low, expected sel high, sel low
   localparam logic [17:0] rows [5] = '{{2'd0, 4'h3, 4'h1, 4'h3, 4'h1}, {2'd0, 4'h4, 4'h0, 4'h7, 4'h1},
      {2'd1, 4'h1, 4'h1, 4'h6, 4'h0}, {2'd2, 4'h8, 4'h0, 4'he, 4'h0}, {2'd1, 4'ha, 4'h0, 4'h4, 4'h0}};
   localparam logic [1:0] gexp [6] = '{2'b01, 2'b11, 2'b10, 2'b00, 2'b10, 2'b11};

   pwm_channel_output_stage #(.DTW(DT_W)) dut_u (.*);
   ext_switch_stage part_u (.hi_pin(output_high_pin), .hi_oe(output_high_oe), .lo_pin(output_low_pin),
      .lo_oe(output_low_oe), .gate_high(gate_high), .gate_low(gate_low), .shoot_through(shoot_through));

   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   task automatic step(input int n);
      repeat (n) @(negedge sys_clk);
   endtask

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   initial begin
      #2000000;
      failures++;
      close_out;
   end

   initial begin
      logic [1:0] op;
      logic [3:0] eh, el;
      nrst = 1'b0;
      {gray_enable_pair0, gray_count_down, override_set_wr, override_clear_wr} = '0;
      {override_set_buffered_wr, override_clear_buffered_wr, fault_clear_wr, fault_irq_status_rd} = '0;
      {period_end, compare_out, deadtime_high_invert, deadtime_low_invert, deadtime_update_wr} = '0;
      {override_wdata_high, override_wdata_low, override_value_low, fault_value_low, fault_tristate_high} = '0;
      {fault_pin, fault_filter_enable, fault_clear_bit, deadtime_high_value, deadtime_low_value} = '0;
      chan_tick = 4'hf;
      chan_enabled = 4'h6;
      sync_group = 4'h2;
      deadtime_enable = 4'h8;
      override_value_high = 4'h5;
      fault_value_high = 4'ha;
      fault_tristate_low = 4'h4;
      fault_irq_enable = 4'h4;
      fault_polarity = 8'hff;
      fault_activation_mode = 8'h02;
      fault_channel_enable = {8'h00, 8'h03, 8'h00, 8'h01};
      step(6);
      nrst = 1'b1;
      step(1);
      chk("sel_rst", 8'h00, 8'(override_sel_high));
      chk("irq_rst", 8'h00, 8'(fault_irq_status));
      $display("reset test done");
      foreach (rows[i]) begin
         {op, override_wdata_high, override_wdata_low, eh, el} = rows[i];
         override_set_wr = (op != 2'd1);
         override_clear_wr = (op != 2'd0);
         step(1);
         {override_set_wr, override_clear_wr} = 2'b00;
         step(1);
         chk("sel_high", 8'(eh), 8'(override_sel_high));
         chk("sel_low", 8'(el), 8'(override_sel_low));
         chk("ovr_pin", 8'(eh & override_value_high), 8'(output_high_pin & eh));
      end
      override_wdata_high = 4'h2;
      for (int k = 0; k < 2; k++) begin
         override_set_buffered_wr = (k == 0);
         override_clear_buffered_wr = (k == 1);
         step(1);
         {override_set_buffered_wr, override_clear_buffered_wr} = 2'b00;
         step(2);
         chk("sel_buf_wait", 8'(4 | (k << 1)), 8'(override_sel_high));
         period_end = 4'h2;
         step(1);
         period_end = 4'h0;
         step(1);
         chk("sel_buf_done", 8'(4 | ((1 - k) << 1)), 8'(override_sel_high));
      end
      $display("override test done");
      fault_pin = 8'h01;
      step(5);
      chk("fault_level", 8'h01, fault_input_level);
      chk("fault_active", 8'h01, fault_active_flags);
      chk("cnt_reset", 8'h06, 8'(counter_reset));
      chk("high_forced", 8'h01, 8'(output_high_pin[2:1]));
      chk("low_oe", 8'h00, 8'(output_low_oe[2]));
      chk("high_oe", 8'h0f, 8'(output_high_oe));
      chk("irq", 8'h01, 8'({fault_irq_status[2], fault_irq} == 2'b11));
      fault_irq_status_rd = 1'b1;
      step(1);
      fault_irq_status_rd = 1'b0;
      step(1);
      chk("irq_read", 8'h00, 8'(fault_irq));
      fault_pin = 8'h00;
      step(5);
      chk("fault_drop", 8'h00, 8'(counter_reset));
      fault_pin = 8'h02;
      step(5);
      fault_pin = 8'h00;
      step(5);
      chk("latched", 8'h02, fault_active_flags);
      chk("sync_enables", 8'h04, 8'(counter_reset));
      fault_clear_bit = 8'h02;
      fault_clear_wr = 1'b1;
      step(1);
      fault_clear_wr = 1'b0;
      step(2);
      chk("cleared", 8'h00, fault_active_flags);
      $display("fault test done");
      gray_enable_pair0 = 1'b1;
      step(1);
      chk("gray_start", 8'h00, 8'(output_high_pin[1:0]));
      for (int k = 0; k < 6; k++) begin
         gray_count_down = (k > 3);
         period_end = 4'h1;
         step(1);
         period_end = 4'h0;
         step(1);
         chk("gray", 8'(gexp[k]), 8'(output_high_pin[1:0]));
      end
      $display("gray test done");
      deadtime_high_value[3] = 16'h0004;
      deadtime_low_value[3] = 16'h0004;
      deadtime_update_wr = 4'h8;
      step(1);
      deadtime_update_wr = 4'h0;
      period_end = 4'h8;
      step(1);
      period_end = 4'h0;
      step(2);
      compare_out = 4'h8;
      step(3);
      chk("dt_gap", 8'h00, 8'({output_high_pin[3], output_low_pin[3]}));
      step(6);
      chk("dt_on", 8'h02, 8'({output_high_pin[3], output_low_pin[3]}));
      chk("shoot", 8'h00, 8'(gate_high[3] & gate_low[3]));
      deadtime_low_invert = 4'h8;
      step(2);
      chk("dt_inv", 8'h03, 8'({output_high_pin[3], output_low_pin[3]}));
      $display("dead time test done");
      close_out;
   end
endmodule
